// ### design/gpt_timer_pair.sv
// Two general purpose timers behind a plain register port
//
// Added by the designer: the plain strobed port and the placing of the registers.
`include "gpt_map.svh"
`default_nettype none
module gpt_timer_pair (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] bus_addr, // Byte offset of the register
  input wire gpt_pkg::gpt_word_t bus_wdata, // Write data
  input wire logic bus_wr, // One-cycle write strobe
  input wire logic bus_rd, // One-cycle read strobe
  output gpt_pkg::gpt_word_t bus_rdata, // Read data, cycle after strobe
  input wire logic osc_32k, // Low rate oscillator, asynchronous
  input wire logic gpio_pin_a, // Count pin A, asynchronous
  input wire logic gpio_pin_b, // Count pin B, asynchronous
  input wire logic [33:0] irq_source, // Interrupt source map, same clock
  output logic timer_a_irq, // Timer A pending interrupt
  output logic timer_b_irq, // Timer B pending interrupt
  output logic adc_start // One-cycle converter start pulse
);
  import gpt_pkg::*;

  // Registers visible to software
  gpt_half_t timer_a_load; // Timer A reload value
  gpt_half_t timer_a_count; // Timer A running count
  gpt_word_t timer_a_control; // Timer A configuration
  gpt_word_t timer_b_load; // Timer B reload value
  gpt_word_t timer_b_count; // Timer B running count
  gpt_word_t timer_b_capture; // Count latched by an event
  gpt_word_t timer_b_control; // Timer B configuration

  // Internal state
  logic a_arm; // Cycle after enable rises: load start value
  logic b_arm; // Same for timer B
  logic [2:0] pin_sync; // Synchronised osc, pin A, pin B
  logic [2:0] pin_prev; // Previous synchronised levels
  logic [33:0] src_prev; // Previous interrupt source levels

  // Address decode
  wire logic wr_a_load = bus_wr && (bus_addr == `GPT_A_LOAD);
  wire logic wr_a_ctl = bus_wr && (bus_addr == `GPT_A_CONTROL);
  wire logic wr_a_clr = bus_wr && (bus_addr == `GPT_A_CLEAR);
  wire logic wr_b_load = bus_wr && (bus_addr == `GPT_B_LOAD);
  wire logic wr_b_ctl = bus_wr && (bus_addr == `GPT_B_CONTROL);
  wire logic wr_b_clr = bus_wr && (bus_addr == `GPT_B_CLEAR);

  // Timer A control fields
  wire logic a_en = timer_a_control[`GPT_EN_BIT];
  wire logic a_per = timer_a_control[`GPT_PER_BIT];
  wire logic [1:0] a_pre = timer_a_control[`GPT_A_PRE_HI:`GPT_A_PRE_LO];

  // Code 11 falls back to divide by one like 00
  wire logic [3:0] a_shift = (a_pre == `GPT_A_PRE_16) ? `GPT_SHIFT_16 :
    (a_pre == `GPT_A_PRE_256) ? `GPT_SHIFT_256 : `GPT_SHIFT_1;

  // Timer B control fields
  wire logic b_en = timer_b_control[`GPT_EN_BIT];
  wire logic b_per = timer_b_control[`GPT_PER_BIT];
  wire logic b_up = timer_b_control[`GPT_UP_BIT];
  wire logic b_cap_en = timer_b_control[`GPT_CAPEN_BIT];
  wire logic [4:0] b_evt = timer_b_control[`GPT_EVT_HI:`GPT_EVT_LO];
  wire logic [2:0] b_src = timer_b_control[`GPT_SRC_HI:`GPT_SRC_LO];
  wire gpt_fmt_t b_fmt = gpt_fmt_t'(timer_b_control[`GPT_FMT_HI:`GPT_FMT_LO]);
  wire logic [3:0] b_pre = timer_b_control[`GPT_B_PRE_HI:`GPT_B_PRE_LO];

  // Unlisted prescale codes divide by one
  wire logic [3:0] b_shift = (b_pre == `GPT_B_PRE_16) ? `GPT_SHIFT_16 :
    (b_pre == `GPT_B_PRE_256) ? `GPT_SHIFT_256 :
    (b_pre == `GPT_B_PRE_32K) ? `GPT_SHIFT_32K : `GPT_SHIFT_1;

  // Synchronise the oscillator and the count pins before edge detection
  gpt_sync #(.W(3)) u_pin_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in({gpio_pin_b, gpio_pin_a, osc_32k}),
    .sync_out(pin_sync)
  );

  // Rising edges of the synchronised levels
  wire logic [2:0] pin_rise = pin_sync & ~pin_prev;

  // Source select; the oscillator is sampled, so it must stay well
  // below half the core clock to be seen
  wire logic b_src_tick = (b_src == `GPT_SRC_CORE) ? 1'b1 :
    (b_src == `GPT_SRC_OSC) ? pin_rise[0] :
    (b_src == `GPT_SRC_PIN_A) ? pin_rise[1] :
    (b_src == `GPT_SRC_PIN_B) ? pin_rise[2] : 1'b0;

  logic a_tick, b_tick; // Prescaled count steps of timer A and timer B

  // Timer A counts core clocks
  gpt_prescaler #(.CW(15)) u_pre_a (
    .sys_clk(sys_clk),
    .reset(reset),
    .run(a_en),
    .tick_in(1'b1),
    .shift(a_shift),
    .tick_out(a_tick)
  );

  // Timer B counts the selected source
  gpt_prescaler #(.CW(15)) u_pre_b (
    .sys_clk(sys_clk),
    .reset(reset),
    .run(b_en),
    .tick_in(b_src_tick),
    .shift(b_shift),
    .tick_out(b_tick)
  );

  // Time format step: hundredths, seconds, minutes, hours in bytes
  function automatic gpt_word_t time_step(input gpt_word_t v, input logic up,
                                          input logic [7:0] hr_last);
    logic [7:0] hu, se, mi, hr; // Hundredths, seconds, minutes, hours
    hu = v[7:0];
    se = v[15:8];
    mi = v[23:16];
    hr = v[31:24];
    if (up)
    begin
      // Carry ripples upward when a field passes its last value
      if (hu < `GPT_HUND_LAST) hu = hu + 8'h01;
      else
      begin
        hu = 8'h00;
        if (se < `GPT_MS_LAST) se = se + 8'h01;
        else
        begin
          se = 8'h00;
          if (mi < `GPT_MS_LAST) mi = mi + 8'h01;
          else
          begin
            mi = 8'h00;
            hr = (hr >= hr_last) ? 8'h00 : hr + 8'h01;
          end
        end
      end
    end
    else
    begin
      // Borrow ripples upward when a field is at zero
      if (hu != 8'h00) hu = hu - 8'h01;
      else
      begin
        hu = `GPT_HUND_LAST;
        if (se != 8'h00) se = se - 8'h01;
        else
        begin
          se = `GPT_MS_LAST;
          if (mi != 8'h00) mi = mi - 8'h01;
          else
          begin
            mi = `GPT_MS_LAST;
            hr = (hr == 8'h00) ? hr_last : hr - 8'h01;
          end
        end
      end
    end
    return {hr, mi, se, hu};
  endfunction : time_step

  // Timer A: down only, terminal value zero
  wire gpt_half_t a_start = a_per ? timer_a_load : 16'hFFFF;
  wire gpt_half_t a_step = (timer_a_count == 16'h0000) ? a_start
    : timer_a_count - 16'h0001;
  wire logic a_set = a_tick && !a_arm && (a_step == 16'h0000);

  // Timer B: time formats limit hours and full scale
  wire logic b_time = (b_fmt == gpt_fmt_t23) || (b_fmt == gpt_fmt_t255);
  wire logic [7:0] b_hr_last = (b_fmt == gpt_fmt_t255) ? `GPT_HR_LAST_255
    : `GPT_HR_LAST_23;
  wire gpt_word_t b_full = b_time ? {b_hr_last, `GPT_MS_LAST, `GPT_MS_LAST,
    `GPT_HUND_LAST} : 32'hFFFF_FFFF;
  wire gpt_word_t b_term = b_up ? b_full : 32'h0000_0000;
  wire gpt_word_t b_start = b_per ? timer_b_load
    : (b_up ? 32'h0000_0000 : b_full);
  wire gpt_word_t b_inc = b_time ? time_step(timer_b_count, b_up, b_hr_last)
    : (b_up ? timer_b_count + 32'h1 : timer_b_count - 32'h1);
  wire gpt_word_t b_step = (timer_b_count == b_term) ? b_start : b_inc;
  wire logic b_set = b_tick && !b_arm && (b_step == b_term);

  // Capture event: source n+2, first assertion only
  wire logic [5:0] evt_idx = {1'b0, b_evt} + `GPT_EVT_OFFSET;
  wire logic cap_hit = b_cap_en && irq_source[evt_idx]
    && !src_prev[evt_idx];

  // Read multiplexer; unmapped and write-only offsets read zero
  wire gpt_word_t rd_mux =
    (bus_addr == `GPT_A_LOAD) ? {16'h0000, timer_a_load} :
    (bus_addr == `GPT_A_COUNT) ? {16'h0000, timer_a_count} :
    (bus_addr == `GPT_A_CONTROL) ? timer_a_control :
    (bus_addr == `GPT_B_LOAD) ? timer_b_load :
    (bus_addr == `GPT_B_COUNT) ? timer_b_count :
    (bus_addr == `GPT_B_CONTROL) ? timer_b_control :
    (bus_addr == `GPT_B_CAPTURE) ? timer_b_capture : 32'h0000_0000;

  // Software registers; reserved control bits never store
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      timer_a_load <= 16'h0000;
      timer_a_control <= `GPT_CTL_RESET;
      timer_b_load <= 32'h0000_0000;
      timer_b_control <= `GPT_CTL_RESET;
    end
    else
    begin
      if (wr_a_load)
        timer_a_load <= bus_wdata[15:0];
      if (wr_a_ctl)
        timer_a_control <= bus_wdata & `GPT_A_CTL_MASK;
      if (wr_b_load)
        timer_b_load <= bus_wdata;
      if (wr_b_ctl)
        timer_b_control <= bus_wdata & `GPT_B_CTL_MASK;
    end
  end

  // Enable rising arms a start-value load one cycle later, so the load
  // sees the mode and format just written
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      a_arm <= 1'b0;
      b_arm <= 1'b0;
    end
    else
    begin
      a_arm <= wr_a_ctl && bus_wdata[`GPT_EN_BIT] && !a_en;
      b_arm <= wr_b_ctl && bus_wdata[`GPT_EN_BIT] && !b_en;
    end
  end

  // Timer A counter; reading never touches it
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      timer_a_count <= 16'h0000;
    else if (a_arm)
      timer_a_count <= a_start;
    else if (a_tick)
      timer_a_count <= a_step;
  end

  // Timer B counter
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      timer_b_count <= 32'h0000_0000;
    else if (b_arm)
      timer_b_count <= b_start;
    else if (b_tick)
      timer_b_count <= b_step;
  end

  // Event capture and edge history
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      timer_b_capture <= 32'h0000_0000;
      src_prev <= '0;
      pin_prev <= 3'h0;
    end
    else
    begin
      src_prev <= irq_source;
      pin_prev <= pin_sync;
      if (cap_hit)
        timer_b_capture <= timer_b_count;
    end
  end

  // Pending interrupts: a terminal event beats a clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      timer_a_irq <= 1'b0;
      timer_b_irq <= 1'b0;
      adc_start <= 1'b0;
    end
    else
    begin
      if (a_set)
        timer_a_irq <= 1'b1;
      else if (wr_a_clr)
        timer_a_irq <= 1'b0;
      if (b_set)
        timer_b_irq <= 1'b1;
      else if (wr_b_clr)
        timer_b_irq <= 1'b0;
      adc_start <= b_set;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      bus_rdata <= 32'h0000_0000;
    else
      bus_rdata <= bus_rd ? rd_mux : 32'h0000_0000;
  end

  // Checks on the block's own outputs and state
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  sequence s_a_clear;
    wr_a_clr && !a_set;
  endsequence
  sequence s_a_wrap_free;
    a_tick && !a_arm && !a_per && (timer_a_count == 16'h0000);
  endsequence
  property p_a_clear;
    s_a_clear |=> !timer_a_irq;
  endproperty
  a_a_clear: assert property (p_a_clear)
    else $error("timer A interrupt not cleared");
  property p_a_raise;
    a_tick && !a_arm && (timer_a_count == 16'h0001) |=> timer_a_irq;
  endproperty
  a_a_raise: assert property (p_a_raise)
    else $error("timer A interrupt missing at zero");
  property p_a_free_wrap;
    s_a_wrap_free |=> (timer_a_count == 16'hFFFF);
  endproperty
  a_a_free_wrap: assert property (p_a_free_wrap)
    else $error("timer A free mode did not restart at maximum");
  property p_a_reload;
    a_tick && !a_arm && a_per && (timer_a_count == 16'h0000)
      |=> (timer_a_count == $past(timer_a_load));
  endproperty
  a_a_reload: assert property (p_a_reload)
    else $error("timer A periodic mode did not reload");
  property p_a_hold;
    !a_en && !a_arm |=> (timer_a_count == $past(timer_a_count));
  endproperty
  a_a_hold: assert property (p_a_hold)
    else $error("timer A counted while disabled");
  property p_a_read;
    bus_rd && (bus_addr == `GPT_A_COUNT)
      |=> (bus_rdata == {16'h0000, $past(timer_a_count)});
  endproperty
  a_a_read: assert property (p_a_read)
    else $error("timer A count read wrong");
  property p_b_up;
    b_tick && !b_arm && b_up && !b_time && (timer_b_count != b_term)
      |=> (timer_b_count == $past(timer_b_count) + 32'h1);
  endproperty
  a_b_up: assert property (p_b_up)
    else $error("timer B did not count up");
  property p_b_capture;
    cap_hit |=> (timer_b_capture == $past(timer_b_count));
  endproperty
  a_b_capture: assert property (p_b_capture)
    else $error("timer B capture missed event");
  // The pulse drops next cycle unless another terminal tick came at once
  property p_b_adc;
    b_set |=> (adc_start && timer_b_irq) ##1 (adc_start == $past(b_set));
  endproperty
  a_b_adc: assert property (p_b_adc)
    else $error("converter start pulse wrong");
endmodule : gpt_timer_pair
`default_nettype wire

// ### design/gpt_map.svh
// Register map, field positions, reset values and counts of the timer pair
// Summary of operation
// - Free mode: full range, then wrap around
// - Periodic mode: start from load, reload at end
// - Count register readable anytime, counter undisturbed
// - Interrupt each time count reaches terminal value
// - Any write to clear register drops interrupt, except in a cycle with a terminal event
// - Timer A: 16-bit down counter, core clock
// - Timer A control bit 7 enables counting
// - Timer A control bit 6 selects periodic
// - Timer A prescale bits 3-2: 1/16/256/1
// - Timer B: 32-bit up/down, read-only count/capture
// - Timer B bits 11-9 select counter source
// - Timer B prescale bits 3-0: 1/16/256/32768
// - Timer B bit 8 selects counting up
// - Timer B bit 7 enable, bit 6 periodic
// - Timer B bits 5-4 select binary or time
// - Selected source first assertion latches capture register
// - Timer B bit 17 enables event capture
// - Event select bits 16-12, event n = source n+2
// - Timer B terminal count pulses converter start
`ifndef GPT_MAP_SVH
`define GPT_MAP_SVH

// Register offsets on the 8-bit register port
`define GPT_A_LOAD 8'h00
`define GPT_A_COUNT 8'h04
`define GPT_A_CONTROL 8'h08
`define GPT_A_CLEAR 8'h0C
`define GPT_B_LOAD 8'h20
`define GPT_B_COUNT 8'h24
`define GPT_B_CONTROL 8'h28
`define GPT_B_CLEAR 8'h2C
`define GPT_B_CAPTURE 8'h30

// Control fields; enable and periodic bits shared by both timers
`define GPT_EN_BIT 7
`define GPT_PER_BIT 6
`define GPT_UP_BIT 8
`define GPT_CAPEN_BIT 17
`define GPT_EVT_HI 16
`define GPT_EVT_LO 12
`define GPT_SRC_HI 11
`define GPT_SRC_LO 9
`define GPT_FMT_HI 5
`define GPT_FMT_LO 4
`define GPT_A_PRE_HI 3
`define GPT_A_PRE_LO 2
`define GPT_B_PRE_HI 3
`define GPT_B_PRE_LO 0

// Writable bits and reset values of the control registers
`define GPT_A_CTL_MASK 32'h0000_00CC
`define GPT_B_CTL_MASK 32'h0003_FFFF
`define GPT_CTL_RESET 32'h0000_0000

// Prescale codes and the divider shift they stand for
`define GPT_A_PRE_16 2'h1
`define GPT_A_PRE_256 2'h2
`define GPT_B_PRE_16 4'h4
`define GPT_B_PRE_256 4'h8
`define GPT_B_PRE_32K 4'hF
`define GPT_SHIFT_1 4'h0
`define GPT_SHIFT_16 4'h4
`define GPT_SHIFT_256 4'h8
`define GPT_SHIFT_32K 4'hF

// Timer B source codes
`define GPT_SRC_CORE 3'h0
`define GPT_SRC_OSC 3'h1
`define GPT_SRC_PIN_A 3'h2
`define GPT_SRC_PIN_B 3'h3

// Event numbering and time format limits
`define GPT_EVT_OFFSET 6'h02
`define GPT_HUND_LAST 8'h63
`define GPT_MS_LAST 8'h3B
`define GPT_HR_LAST_23 8'h17
`define GPT_HR_LAST_255 8'hFF

`endif

// ### design/gpt_pkg.sv
// Types shared by the timer pair modules
`default_nettype none
package gpt_pkg;
  typedef logic [31:0] gpt_word_t; // Timer B and bus word
  typedef logic [15:0] gpt_half_t; // Timer A word
  // Timer B count format, codes fixed by the control field
  typedef enum logic [1:0] {
    gpt_fmt_bin = 2'h0,
    gpt_fmt_rsvd = 2'h1,
    gpt_fmt_t23 = 2'h2,
    gpt_fmt_t255 = 2'h3
  } gpt_fmt_t;
endpackage : gpt_pkg
`default_nettype wire

// ### design/gpt_sync.sv
// Two-flop synchroniser for a group of pin levels
`default_nettype none
module gpt_sync #(
  parameter int W = 3 // Number of levels
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  if (W < 1) begin : g_bad_w
    $error("gpt_sync: W must be at least 1");
  end

  logic [W-1:0] stage1; // Only the second stage reads this

  // Two stages to settle metastability
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : gpt_sync
`default_nettype wire

// ### design/gpt_prescaler.sv
// Power-of-two prescaler giving one tick per 2**shift input ticks
`default_nettype none
module gpt_prescaler #(
  parameter int CW = 15 // Counter width, sets the largest shift
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic tick_in,
  input wire logic [3:0] shift,
  output logic tick_out
);
  if (CW < 1 || CW > 15) begin : g_bad_cw
    $error("gpt_prescaler: CW must be 1 to 15");
  end

  logic [CW-1:0] cnt; // Input ticks seen so far
  wire logic [CW-1:0] mask = CW'((32'h1 << shift) - 32'h1); // Low bits to fill

  // Tick leaves when every counted bit is set; shift 0 passes all ticks
  assign tick_out = run && tick_in && ((cnt & mask) == mask);

  // Held clear while stopped so a restart begins a full prescale period
  always_ff @(posedge sys_clk)
  begin
    if (reset || !run)
      cnt <= '0;
    else if (tick_in)
      cnt <= tick_out ? '0 : cnt + CW'(1);
  end
endmodule : gpt_prescaler
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the general purpose timer pair
`include "gpt_map.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import gpt_pkg::*;

  logic sys_clk; // 20 MHz core clock
  logic reset; // Synchronous, active high
  logic [7:0] bus_addr;
  gpt_word_t bus_wdata;
  logic bus_wr;
  logic bus_rd;
  gpt_word_t bus_rdata;
  logic osc_32k;
  logic gpio_pin_a;
  logic gpio_pin_b;
  logic [33:0] irq_source;
  logic timer_a_irq;
  logic timer_b_irq;
  logic adc_start;
  int errors = 0; // Mismatches
  int comparisons = 0; // Checks made
  logic [31:0] rnd = 32'h1518DD47; // Fixed seed keeps runs repeatable
  gpt_word_t d; // Last read value
  gpt_word_t cap_x; // Frozen count expected in capture
  int a_cnt = 0;
  int b_cnt = 0;
  int a_gap = 0; // Cycles between the last two timer A interrupt rises
  int b_gap = 0;
  int a_rises = 0;
  int b_rises = 0;
  logic a_prev = 1'b0;
  logic b_prev = 1'b0;
  logic [7:0] tb_base [5] = '{8'h00, 8'h20, 8'h20, 8'h20, 8'h20};
  logic [31:0] tb_load [5] = '{32'h0, 32'h0, 32'h0, 32'h0000_3B62, 32'h0001_0000};
  logic [31:0] tb_ctl [5] = '{32'h80, 32'h80, 32'h180, 32'h1E0, 32'hE0};
  logic [31:0] tb_s1 [5] = '{32'hFFFF, 32'hFFFF_FFFF, 32'h0, 32'h3B62, 32'h1_0000};
  logic [31:0] tb_s2 [5] = '{32'hFFFD, 32'hFFFF_FFFD, 32'h2, 32'h1_0000, 32'h3B62};
  int div_a [4] = '{1, 16, 256, 1};
  int div_b [3] = '{1, 16, 256};

  gpt_timer_pair dut_u (
    .sys_clk(sys_clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .osc_32k(osc_32k),
    .gpio_pin_a(gpio_pin_a), .gpio_pin_b(gpio_pin_b), .irq_source(irq_source),
    .timer_a_irq(timer_a_irq), .timer_b_irq(timer_b_irq), .adc_start(adc_start)
  );

  // Free running clock, 50 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic fail(input string msg);
    errors++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask : fail

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // Linear feedback shift register, advances the shared random word
  function automatic void rnd_step();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
  endfunction : rnd_step

  task automatic print_verdict;
    $display("Checks made: %0d, mismatches: %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask : wr

  // Read data is taken in the one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 v = bus_rdata;
  endtask : rd

  task automatic wait_rise(input logic sel_b);
    int start;
    int n;
    start = sel_b ? b_rises : a_rises;
    n = 0;
    while ((sel_b ? b_rises : a_rises) == start && n < 20000)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 20000)
      fail("no interrupt");
    #1;
  endtask : wait_rise

  // Two interrupts, each cleared with random data, then the period between them
  task automatic period_check(input logic sel_b, input logic [31:0] ld,
                              input logic [31:0] ctl, input int gap);
    logic [7:0] base;
    base = sel_b ? 8'h20 : 8'h00;
    wr(base, ld);
    wr(base + 8'h08, ctl);
    repeat (2)
    begin
      wait_rise(sel_b);
      chk({31'h0, sel_b ? timer_b_irq : timer_a_irq}, 32'h1, "irq not held");
      rnd_step;
      wr(base + 8'h0C, {24'h0, rnd[7:0]});
      #1 chk({31'h0, sel_b ? timer_b_irq : timer_a_irq}, 32'h0, "irq not cleared");
    end
    chk(32'(sel_b ? b_gap : a_gap), 32'(gap), "interrupt period");
    wr(base + 8'h08, 32'h0);
  endtask : period_check

  task automatic pulse_src(input int k);
    @(posedge sys_clk);
    irq_source[k] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    irq_source[k] <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : pulse_src

  // Oscillator gets 3 rising edges, pin A 5, pin B 7
  task automatic pulse_pins;
    for (int i = 0; i < 7; i++)
    begin
      @(posedge sys_clk);
      osc_32k <= (i < 3);
      gpio_pin_a <= (i < 5);
      gpio_pin_b <= 1'b1;
      repeat (3) @(posedge sys_clk);
      osc_32k <= 1'b0;
      gpio_pin_a <= 1'b0;
      gpio_pin_b <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
    repeat (8) @(posedge sys_clk);
  endtask : pulse_pins

  // Interrupt edge timing, and converter start tied to timer B interrupt rise
  always @(posedge sys_clk)
  begin
    if (adc_start === 1'b1)
      comparisons++;
    if ((timer_b_irq === 1'b1 && b_prev !== 1'b1) != (adc_start === 1'b1))
      fail("converter start not with timer B interrupt rise");
    if (timer_a_irq === 1'b1 && a_prev !== 1'b1)
    begin
      a_gap = a_cnt;
      a_cnt = 1;
      a_rises++;
    end
    else
      a_cnt++;
    if (timer_b_irq === 1'b1 && b_prev !== 1'b1)
    begin
      b_gap = b_cnt;
      b_cnt = 1;
      b_rises++;
    end
    else
      b_cnt++;
    a_prev = timer_a_irq;
    b_prev = timer_b_irq;
  end

  // Watchdog cuts a hang short
  initial
  begin
    repeat (80000) @(posedge sys_clk);
    fail("timeout");
    print_verdict();
  end

  // Main sequence
  initial
  begin
    reset = 1'b1;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    osc_32k = 1'b0;
    gpio_pin_a = 1'b0;
    gpio_pin_b = 1'b0;
    irq_source = 34'h0;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    // Reset state of controls, count and capture
    foreach (tb_base[i])
    begin
      rd(8'h08 + tb_base[i & 1], d);
      chk(d, 32'h0, "control reset");
    end
    rd(`GPT_B_COUNT, d);
    chk(d, 32'h0, "count reset");
    rd(`GPT_B_CAPTURE, d);
    chk(d, 32'h0, "capture reset");
    chk({30'h0, timer_a_irq, timer_b_irq}, 32'h0, "irq after reset");
    // Load widths, read-only count, unmapped and write-only offsets
    rnd_step;
    wr(`GPT_A_LOAD, rnd);
    rd(`GPT_A_LOAD, d);
    chk(d, {16'h0, rnd[15:0]}, "A load");
    wr(`GPT_B_LOAD, rnd);
    rd(`GPT_B_LOAD, d);
    chk(d, rnd, "B load");
    wr(`GPT_B_COUNT, rnd);
    rd(`GPT_B_COUNT, d);
    chk(d, 32'h0, "count written");
    rd(8'h40, d);
    chk(d, 32'h0, "unmapped read");
    rd(`GPT_A_CLEAR, d);
    chk(d, 32'h0, "clear read");
    // Reserved control bits with random data, enable kept off
    repeat (4)
    begin
      rnd_step;
      wr(`GPT_A_CONTROL, rnd & ~32'h80);
      rd(`GPT_A_CONTROL, d);
      chk(d, rnd & 32'h0000_004C, "A control bits");
      wr(`GPT_B_CONTROL, rnd & ~32'h80);
      rd(`GPT_B_CONTROL, d);
      chk(d, rnd & 32'h0003_FF7F, "B control bits");
    end
    wr(`GPT_A_CONTROL, 32'h0);
    wr(`GPT_B_CONTROL, 32'h0);
    // Start values and undisturbed stepping, binary and time formats
    for (int i = 0; i < 5; i++)
    begin
      wr(tb_base[i], tb_load[i]);
      wr(tb_base[i] + 8'h08, tb_ctl[i]);
      rd(tb_base[i] + 8'h04, d);
      chk(d, tb_s1[i], "start value");
      rd(tb_base[i] + 8'h04, d);
      chk(d, tb_s2[i], "count two ticks on");
      wr(tb_base[i] + 8'h08, 32'h0);
    end
    // Timer A prescale codes in periodic mode
    for (int c = 0; c < 4; c++)
    begin
      rnd_step;
      period_check(1'b0, 32'(8 + rnd[2:0]), 32'hC0 | 32'(c << 2),
                   (9 + rnd[2:0]) * div_a[c]);
    end
    // Timer B prescale codes, down then up
    for (int c = 0; c < 3; c++)
    begin
      rnd_step;
      period_check(1'b1, 32'(8 + rnd[2:0]), 32'hC0 | 32'(c << 2),
                   (9 + rnd[2:0]) * div_b[c]);
    end
    period_check(1'b1, 32'hFFFF_FFF6, 32'h1C0, 10);
    period_check(1'b1, 32'h173B_3B5A, 32'h1E0, 10);
    period_check(1'b1, 32'hFF3B_3B5A, 32'h1F0, 10);
    wr(`GPT_B_LOAD, 32'h5);
    wr(`GPT_B_CONTROL, 32'hCF);
    rd(`GPT_B_COUNT, d);
    rd(`GPT_B_COUNT, d);
    chk(d, 32'h5, "no tick before 32768 cycles");
    wr(`GPT_B_CONTROL, 32'h0);
    // Oscillator and pin sources each count only their own edges
    for (int s = 1; s < 4; s++)
    begin
      wr(`GPT_B_LOAD, 32'h64);
      wr(`GPT_B_CONTROL, 32'hC0 | 32'(s << 9));
      repeat (4) @(posedge sys_clk);
      pulse_pins();
      rd(`GPT_B_COUNT, d);
      chk(d, 32'h64 - 32'(2 * s + 1), "source edges counted");
      wr(`GPT_B_CONTROL, 32'h0);
    end
    // Event capture: wrong event, right event, capture disabled
    rnd_step;
    wr(`GPT_B_CONTROL, {14'h0, 1'b1, rnd[4:0], 12'h080});
    repeat (5) @(posedge sys_clk);
    wr(`GPT_B_CONTROL, {14'h0, 1'b1, rnd[4:0], 12'h000});
    rd(`GPT_B_COUNT, cap_x);
    pulse_src(32'(rnd[4:0] ^ 5'h01) + 2);
    rd(`GPT_B_CAPTURE, d);
    chk(d, 32'h0, "capture on other event");
    pulse_src(32'(rnd[4:0]) + 2);
    rd(`GPT_B_CAPTURE, d);
    chk(d, cap_x, "capture on selected event");
    wr(`GPT_B_CONTROL, {14'h0, 1'b0, rnd[4:0], 12'h180});
    repeat (5) @(posedge sys_clk);
    wr(`GPT_B_CONTROL, {14'h0, 1'b0, rnd[4:0], 12'h100});
    pulse_src(32'(rnd[4:0]) + 2);
    rd(`GPT_B_CAPTURE, d);
    chk(d, cap_x, "capture while disabled");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
